// ===== hw/spr_dev_end.sv
// Device end of the serial port: command decode, register access, FIFO read, upset check
`default_nettype none
module spr_dev_end
   import spr_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   spr_if.dev link,
   input wire logic [7:0] reg_rd_data,
   input wire logic [SAMPLE_W-1:0] fifo_sample,
   input wire logic inj_en,
   input wire logic [6:0] inj_bit,
   output logic [5:0] reg_rd_addr,
   output logic reg_wr_stb,
   output logic [5:0] reg_wr_addr,
   output logic [7:0] reg_wr_data,
   output logic [GUARD_REGS*8-1:0] cfg_regs,
   output logic fifo_pop,
   output logic drdy_clr,
   output logic err_user_regs
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [CODE_CHK:0] spr_code(input logic [CODE_DATA-1:0] d);
      logic [CODE_CHK:0] c;
      int k;
      c = '0;
      k = 0;
      for (int p = 1; p < CODE_BITS; p++) begin
         if ((p & (p - 1)) != 0) begin
            for (int j = 0; j < CODE_CHK; j++) begin
               if (p[j]) begin
                  c[j] = c[j] ^ d[k];
               end
            end
            c[CODE_CHK] = c[CODE_CHK] ^ d[k];
            k++;
         end
      end
      // Overall parity over data and check bits tells single from double errors
      c[CODE_CHK] = c[CODE_CHK] ^ (^c[CODE_CHK-1:0]);
      return c;
   endfunction : spr_code

   function automatic logic is_guarded(input logic [5:0] a);
      return (a >= GUARD_LO) && (a <= GUARD_HI);
   endfunction : is_guarded

   function automatic logic is_data_reg(input logic [5:0] a);
      return ((a >= DATA_A_LO) && (a <= DATA_A_HI)) || ((a >= DATA_B_LO) && (a <= DATA_B_HI));
   endfunction : is_data_reg

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: index 0 chip select, 1 clock, 2 data in
   logic [2:0] pin_in;
   logic [2:0] filt_ff;
   logic [SYNC_STAGES-1:0] sync_ff [3];
   assign pin_in = {link.mosi, link.sclk, link.cs_n};

   for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            // Start at the pins' idle levels so no false select follows release
            sync_ff[g] <= {SYNC_STAGES{g == 0}};
            filt_ff[g] <= (g == 0) ? 1'b1 : 1'b0;
         end else if (ce) begin
            sync_ff[g] <= {sync_ff[g][SYNC_STAGES-2:0], pin_in[g]};
            if (sync_ff[g][1] == sync_ff[g][2]) begin
               filt_ff[g] <= sync_ff[g][2];
            end
         end
      end
   end

   logic sclk_prev_ff;
   logic sclk_rise;
   logic sclk_fall;
   logic sel;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_prev_ff <= 1'b0;
      end else if (ce) begin
         sclk_prev_ff <= filt_ff[1];
      end
   end
   assign sel = ~filt_ff[0];
   assign sclk_rise = sel & filt_ff[1] & ~sclk_prev_ff;
   assign sclk_fall = sel & ~filt_ff[1] & sclk_prev_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Byte framing
   spr_dev_state_t state_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] rx_sh_ff;
   logic [7:0] rx_byte;
   logic byte_done;
   logic [5:0] addr_ff;
   logic [5:0] addr_map;
   logic wr_cmd_ff;
   assign rx_byte = {rx_sh_ff[6:0], filt_ff[2]};
   assign byte_done = sclk_rise && (bit_cnt_ff == LAST_BIT);
   assign addr_map = (rx_byte > 8'(ADDR_INVALID)) ? ADDR_INVALID : rx_byte[5:0];

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bit_cnt_ff <= '0;
         rx_sh_ff <= '0;
      end else if (ce) begin
         if (!sel) begin
            bit_cnt_ff <= '0;
         end else if (sclk_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            rx_sh_ff <= rx_byte;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= SPR_CMD;
      end else if (ce) begin
         if (!sel) begin
            state_ff <= SPR_CMD;
         end else if (byte_done) begin
            case (state_ff)
               SPR_CMD: begin
                  case (rx_byte)
                     CMD_WR, CMD_RD: state_ff <= SPR_ADDR;
                     CMD_FIFO: state_ff <= SPR_FIFO;
                     default: state_ff <= SPR_IGN;
                  endcase
               end
               SPR_ADDR: state_ff <= wr_cmd_ff ? SPR_WR : SPR_RD;
               default: state_ff <= state_ff;
            endcase
         end
      end
   end

   // The shifter has moved on by the end of the address byte, so the command kind is kept
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_cmd_ff <= 1'b0;
      end else if (ce && byte_done && state_ff == SPR_CMD) begin
         wr_cmd_ff <= (rx_byte == CMD_WR);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         addr_ff <= '0;
      end else if (ce && byte_done) begin
         if (state_ff == SPR_ADDR) begin
            addr_ff <= addr_map;
         end else if ((state_ff == SPR_WR || state_ff == SPR_RD) && addr_ff != ADDR_INVALID) begin
            addr_ff <= addr_ff + 6'h1;
         end
      end
   end
   assign reg_rd_addr = addr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, guarded bank and upset check
   logic [GUARD_REGS-1:0][7:0] bank_ff;
   logic [GUARD_REGS*8-1:0] inj_mask;
   logic wr_hit;
   logic wr_any;
   logic chk_upd_ff;
   logic [CODE_CHK:0] chk_ff;
   logic [CODE_CHK:0] chk_live;
   logic pwr_err_ff;
   logic err_ff;
   logic wr_stb_ff;
   logic [5:0] wr_addr_ff;
   logic [7:0] wr_data_ff;

   assign wr_any = byte_done && (state_ff == SPR_WR);
   assign wr_hit = wr_any && (addr_ff != ADDR_INVALID);
   assign inj_mask = (GUARD_REGS * 8)'(1) << inj_bit;
   assign chk_live = spr_code(cfg_regs[CODE_DATA-1:0]);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bank_ff <= '0;
      end else if (ce) begin
         if (wr_hit && is_guarded(addr_ff)) begin
            bank_ff[addr_ff - GUARD_LO] <= rx_byte;
         end else if (inj_en) begin
            // Upset injection flips a bit behind the check's back
            bank_ff <= bank_ff ^ inj_mask;
         end
      end
   end
   assign cfg_regs = bank_ff;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         chk_upd_ff <= 1'b0;
         chk_ff <= '0;
      end else if (ce) begin
         chk_upd_ff <= wr_hit && is_guarded(addr_ff);
         if (chk_upd_ff) begin
            chk_ff <= chk_live;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_err_ff <= ERR_AT_RESET;
         err_ff <= ERR_AT_RESET;
      end else if (ce) begin
         if (wr_hit) begin
            pwr_err_ff <= 1'b0;
         end
         // The cycle right after a guarded write still holds old check bits, so its compare is masked
         err_ff <= pwr_err_ff || ((chk_ff != chk_live) && !chk_upd_ff);
      end
   end
   assign err_user_regs = err_ff;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_stb_ff <= 1'b0;
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
      end else if (ce) begin
         wr_stb_ff <= wr_hit;
         if (wr_hit) begin
            wr_addr_ff <= addr_ff;
            wr_data_ff <= rx_byte;
         end
      end
   end
   assign reg_wr_stb = wr_stb_ff;
   assign reg_wr_addr = wr_addr_ff;
   assign reg_wr_data = wr_data_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Read data path: loads on the falling edge that opens each data byte
   logic [7:0] tx_sh_ff;
   logic [7:0] rd_byte;
   logic miso_ff;
   logic oe_ff;
   logic half_ff;
   logic [SAMPLE_W-1:0] sample_ff;
   logic pop_ff;
   logic drdy_ff;
   logic load;
   logic commit;

   assign load = sclk_fall && (bit_cnt_ff == '0) && (state_ff == SPR_RD || state_ff == SPR_FIFO);
   // The closing fall of a frame looks like an opening one, so side effects wait for the first rise
   assign commit = sclk_rise && (bit_cnt_ff == '0) && (state_ff == SPR_RD || state_ff == SPR_FIFO);
   always_comb begin
      if (addr_ff == ADDR_INVALID) begin
         rd_byte = IDLE_BYTE;
      end else if (is_guarded(addr_ff)) begin
         rd_byte = bank_ff[addr_ff - GUARD_LO];
      end else begin
         rd_byte = reg_rd_data;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_sh_ff <= '0;
         miso_ff <= 1'b0;
         oe_ff <= 1'b0;
         half_ff <= 1'b0;
         sample_ff <= '0;
      end else if (ce) begin
         if (!sel || state_ff == SPR_IGN || state_ff == SPR_WR) begin
            oe_ff <= 1'b0;
            half_ff <= 1'b0;
         end else if (load && state_ff == SPR_FIFO) begin
            oe_ff <= 1'b1;
            half_ff <= ~half_ff;
            if (!half_ff) begin
               sample_ff <= fifo_sample;
               miso_ff <= fifo_sample[7];
               tx_sh_ff <= {fifo_sample[6:0], 1'b0};
            end else begin
               miso_ff <= sample_ff[SAMPLE_W-1];
               tx_sh_ff <= {sample_ff[SAMPLE_W-2:8], 1'b0};
            end
         end else if (load) begin
            oe_ff <= 1'b1;
            miso_ff <= rd_byte[7];
            tx_sh_ff <= {rd_byte[6:0], 1'b0};
         end else if (sclk_fall) begin
            miso_ff <= tx_sh_ff[7];
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
         end
      end
   end
   assign link.miso_o = miso_ff;
   assign link.miso_oe = oe_ff;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pop_ff <= 1'b0;
         drdy_ff <= 1'b0;
      end else if (ce) begin
         pop_ff <= commit && (state_ff == SPR_FIFO) && half_ff;
         drdy_ff <= commit && (state_ff == SPR_RD) && is_data_reg(addr_ff);
      end
   end
   assign fifo_pop = pop_ff;
   assign drdy_clr = drdy_ff;

endmodule : spr_dev_end
`default_nettype wire

// ===== hw/spr_host_end.sv
// Host end of the serial port: makes the serial clock and runs one transaction per request
`default_nettype none
module spr_host_end
   import spr_pkg::*;
#(
   parameter int HALF = SCLK_HALF_CYC,
   parameter int LEN_W = 8
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   spr_if.host link,
   input wire logic req,
   input wire logic [7:0] req_cmd,
   input wire logic [7:0] req_addr,
   input wire logic [LEN_W-1:0] req_len,
   input wire logic [7:0] wr_byte,
   output logic wr_take,
   output logic [7:0] rd_byte,
   output logic rd_valid,
   output logic busy
);

   ////////////////////////////////////////////////////////////////////////////
   logic [SYNC_STAGES-1:0] miso_sync_ff;
   logic miso_filt_ff;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         miso_sync_ff <= '0;
         miso_filt_ff <= 1'b0;
      end else if (ce) begin
         miso_sync_ff <= {miso_sync_ff[SYNC_STAGES-2:0], link.miso};
         if (miso_sync_ff[1] == miso_sync_ff[2]) begin
            miso_filt_ff <= miso_sync_ff[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   spr_host_state_t state_ff;
   logic [15:0] cnt_ff;
   logic cnt_end;
   logic cs_n_ff;
   logic sclk_ff;
   logic mosi_ff;
   logic [7:0] tx_sh_ff;
   logic [7:0] rx_sh_ff;
   logic [2:0] bit_cnt_ff;
   logic [LEN_W:0] idx_ff;
   logic [LEN_W:0] total_ff;
   logic [LEN_W:0] hdr_ff;
   logic [7:0] cmd_ff;
   logic [7:0] addr_ff;
   logic [7:0] next_byte;
   logic [LEN_W:0] next_idx;
   logic take_ff;
   logic rd_valid_ff;
   logic [7:0] rd_byte_ff;
   logic is_read;
   logic busy_ff;

   assign cnt_end = (cnt_ff == 16'(HALF - 1));
   assign next_idx = idx_ff + (LEN_W + 1)'(1);
   assign is_read = (cmd_ff == CMD_RD) || (cmd_ff == CMD_FIFO);

   always_comb begin
      if (next_idx == (LEN_W + 1)'(1) && hdr_ff == (LEN_W + 1)'(2)) begin
         next_byte = addr_ff;
      end else if (cmd_ff == CMD_WR) begin
         next_byte = wr_byte;
      end else begin
         next_byte = IDLE_BYTE;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= SPR_H_IDLE;
         cnt_ff <= '0;
         cs_n_ff <= 1'b1;
         sclk_ff <= 1'b0;
         mosi_ff <= 1'b0;
         tx_sh_ff <= '0;
         rx_sh_ff <= '0;
         bit_cnt_ff <= '0;
         idx_ff <= '0;
         total_ff <= '0;
         hdr_ff <= '0;
         cmd_ff <= '0;
         addr_ff <= '0;
         take_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         rd_byte_ff <= '0;
         busy_ff <= 1'b0;
      end else if (ce) begin
         take_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         cnt_ff <= cnt_end ? '0 : cnt_ff + 16'h1;
         case (state_ff)
            SPR_H_IDLE: begin
               cnt_ff <= '0;
               if (req) begin
                  cmd_ff <= req_cmd;
                  addr_ff <= req_addr;
                  // Register commands carry an address byte, the FIFO read does not
                  hdr_ff <= (req_cmd == CMD_WR || req_cmd == CMD_RD) ? (LEN_W + 1)'(2) : (LEN_W + 1)'(1);
                  total_ff <= (LEN_W + 1)'(req_len) +
                     ((req_cmd == CMD_WR || req_cmd == CMD_RD) ? (LEN_W + 1)'(2) : (LEN_W + 1)'(1));
                  idx_ff <= '0;
                  bit_cnt_ff <= '0;
                  cs_n_ff <= 1'b0;
                  mosi_ff <= req_cmd[7];
                  tx_sh_ff <= {req_cmd[6:0], 1'b0};
                  state_ff <= SPR_H_LOW;
                  busy_ff <= 1'b1;
               end
            end
            SPR_H_LOW: begin
               if (cnt_end) begin
                  sclk_ff <= 1'b1;
                  rx_sh_ff <= {rx_sh_ff[6:0], miso_filt_ff};
                  state_ff <= SPR_H_HIGH;
               end
            end
            SPR_H_HIGH: begin
               if (cnt_end) begin
                  sclk_ff <= 1'b0;
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  state_ff <= SPR_H_LOW;
                  if (bit_cnt_ff == LAST_BIT) begin
                     idx_ff <= next_idx;
                     if (idx_ff >= hdr_ff && is_read) begin
                        rd_valid_ff <= 1'b1;
                        rd_byte_ff <= rx_sh_ff;
                     end
                     if (next_idx >= total_ff) begin
                        state_ff <= SPR_H_TAIL;
                     end else begin
                        take_ff <= (cmd_ff == CMD_WR) && (next_idx >= hdr_ff);
                        mosi_ff <= next_byte[7];
                        tx_sh_ff <= {next_byte[6:0], 1'b0};
                     end
                  end else begin
                     mosi_ff <= tx_sh_ff[7];
                     tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                  end
               end
            end
            SPR_H_TAIL: begin
               if (cnt_end) begin
                  cs_n_ff <= 1'b1;
                  state_ff <= SPR_H_GAP;
               end
            end
            SPR_H_GAP: begin
               if (cnt_end) begin
                  state_ff <= SPR_H_IDLE;
                  busy_ff <= 1'b0;
               end
            end
            default: state_ff <= SPR_H_IDLE;
         endcase
      end
   end

   assign link.cs_n = cs_n_ff;
   assign link.sclk = sclk_ff;
   assign link.mosi = mosi_ff;
   assign wr_take = take_ff;
   assign rd_byte = rd_byte_ff;
   assign rd_valid = rd_valid_ff;
   assign busy = busy_ff;

endmodule : spr_host_end
`default_nettype wire

// ===== hw/spr_if.sv
// Four-wire serial link joining the device end and the host end
`default_nettype none
interface spr_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso_keep;
   logic miso;
   // Bus keeper: holds the last driven level while the device releases MISO
   always_latch begin
      if (miso_oe) begin
         miso_keep = miso_o;
      end
   end
   assign miso = miso_oe ? miso_o : miso_keep;
   modport dev (input cs_n, input sclk, input mosi, output miso_o, output miso_oe);
   modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : spr_if
`default_nettype wire

// ===== hw/spr_pkg.sv
// Shared constants and types for the SPI register port and its host
// Notes on behaviour
// - Check bits guard the low 91 bits of registers 0x20 to 0x2E
// - Hamming code over 99 bits, double detection
// - Any guarded write recomputes stored check bits
// - Stored and live check mismatch sets error
// - Error set at power-up, cleared by write
// - Host ignores MISO during register writes
// - MISO released except while shifting read data
// - Mode 0: clock idles low, rising samples
// - First byte is command: 0A, 0B, 0D
// - Host sends command, address, data, then releases
// - FIFO read has no address byte
// - Sample is 2-bit tag plus 14-bit value
// - Sample low byte first, high byte second
// - Odd FIFO read drops last sample's upper half
// - Host should read FIFO in even byte counts; host end accepts odd counts, bench reads a single byte once
// - Bursts of any length for all commands
// - FIFO paced by serial clock during reads
// - Burst address increments, sticks at 0x3F
// - Addresses above 63 map to 0x3F, no effect
// - Host uses addresses 0x00 to 0x2E only; host end passes any 8-bit address, bench also sends 0x3E and 0x85
// - Reading data registers clears data-ready indication
// - Unknown command ignored, MISO stays released
`default_nettype none
package spr_pkg;
   localparam logic [7:0] CMD_WR = 8'h0a;
   localparam logic [7:0] CMD_RD = 8'h0b;
   localparam logic [7:0] CMD_FIFO = 8'h0d;
   localparam logic [7:0] IDLE_BYTE = 8'h00;
   localparam logic [5:0] ADDR_INVALID = 6'h3f;
   localparam logic [5:0] GUARD_LO = 6'h20;
   localparam logic [5:0] GUARD_HI = 6'h2e;
   localparam logic [5:0] DATA_A_LO = 6'h08;
   localparam logic [5:0] DATA_A_HI = 6'h0a;
   localparam logic [5:0] DATA_B_LO = 6'h0e;
   localparam logic [5:0] DATA_B_HI = 6'h15;
   localparam int GUARD_REGS = 15;
   localparam int CODE_BITS = 99;
   localparam int CODE_DATA = 91;
   localparam int CODE_CHK = 7;
   localparam int SAMPLE_TAG_W = 2;
   localparam int SAMPLE_VAL_W = 14;
   localparam int SAMPLE_W = SAMPLE_TAG_W + SAMPLE_VAL_W;
   localparam int SYNC_STAGES = 3;
   localparam int SCLK_HALF_CYC = 10;
   localparam logic ERR_AT_RESET = 1'b1;
   localparam logic [2:0] LAST_BIT = 3'h7;
   typedef enum logic [2:0] {SPR_CMD, SPR_ADDR, SPR_WR, SPR_RD, SPR_FIFO, SPR_IGN} spr_dev_state_t;
   typedef enum logic [2:0] {SPR_H_IDLE, SPR_H_LOW, SPR_H_HIGH, SPR_H_TAIL, SPR_H_GAP} spr_host_state_t;
endpackage : spr_pkg
`default_nettype wire

// ===== verif/spr_link_properties.sv
// Concurrent checks on the serial link between host end and device end
`default_nettype none
module spr_link_properties
   import spr_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe
);
   logic sclk_d_ff;
   logic [7:0] bits_ff;
   logic [7:0] cmd_ff;
   logic rise;
   assign rise = sclk && !sclk_d_ff && !cs_n;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_d_ff <= 1'b0;
      end else begin
         sclk_d_ff <= sclk;
      end
   end
   // Bit count of the frame; wraps only on frames far longer than the bench sends
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bits_ff <= 8'h00;
      end else if (cs_n) begin
         bits_ff <= 8'h00;
      end else if (rise) begin
         bits_ff <= bits_ff + 8'h01;
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_ff <= 8'h00;
      end else if (rise && bits_ff < 8'h08) begin
         cmd_ff <= {cmd_ff[6:0], mosi};
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Host end runs with a half period of 10 cycles
   sequence s_high_half;
      sclk [*8] ##1 sclk [*2] ##1 !sclk;
   endsequence
   sequence s_byte_end(logic [7:0] c, int n);
      $fell(sclk) && !cs_n && bits_ff == n && cmd_ff == c;
   endsequence
   a_clock_idle: assert property (cs_n |-> !sclk)
      else $error("serial clock not low outside frame");
   a_half_period: assert property ($rose(sclk) |-> s_high_half)
      else $error("serial clock high phase wrong length");
   a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("mosi moved while clock high");
   a_miso_steady: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso_o))
      else $error("miso moved while clock high");
   a_release_late: assert property ($rose(cs_n) |-> ##12 !miso_oe)
      else $error("miso still driven after frame end");
   a_oe_start: assert property ($rose(miso_oe) |-> !cs_n && !sclk)
      else $error("miso driven at wrong moment");
   a_byte_framing: assert property ($rose(cs_n) |-> bits_ff[2:0] == 3'h0)
      else $error("frame ended inside a byte");
   a_quiet_cmd: assert property (!cs_n && bits_ff >= 8 && cmd_ff != CMD_RD && cmd_ff != CMD_FIFO |-> !miso_oe)
      else $error("miso driven for a non-read command");
   a_fifo_answer: assert property (s_byte_end(CMD_FIFO, 8) |-> ##[1:8] miso_oe)
      else $error("no fifo data after command byte");
   a_no_early_read: assert property (s_byte_end(CMD_RD, 8) |-> !miso_oe [*8])
      else $error("miso driven during address byte");
   a_read_answer: assert property (s_byte_end(CMD_RD, 16) |-> ##[1:8] miso_oe)
      else $error("no read data after address byte");
endmodule : spr_link_properties
`default_nettype wire

// ===== verif/tb_spi_register_port_with_seu_check.sv
// Self-checking bench joining host end and device end over the serial link
`default_nettype none
module tb_spi_register_port_with_seu_check;
   import spr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] adr;
      logic [7:0] len;
      logic [7:0] w0;
      logic [7:0] nrd;
      logic [7:0] e0;
      logic [7:0] e1;
      logic [7:0] nd;
      logic [7:0] nwr;
   } spr_row_t;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic req = 1'b0;
   logic [7:0] req_cmd = 8'h00;
   logic [7:0] req_addr = 8'h00;
   logic [7:0] req_len = 8'h00;
   logic [7:0] wr_byte = 8'h00;
   logic inj_en = 1'b0;
   logic [6:0] inj_bit = 7'h00;
   logic [7:0] fcnt = 8'h31;
   logic wr_take, rd_valid, busy, reg_wr_stb, fifo_pop, drdy_clr, err;
   logic [7:0] rd_byte, reg_wr_data;
   logic [5:0] reg_rd_addr, reg_wr_addr;
   logic [GUARD_REGS*8-1:0] cfg_regs;
   logic [7:0] rq[$];
   logic [13:0] wq[$];
   int ndrdy;
   int failures = 0;
   int samples_checked = 0;
   // Rows: cmd, addr, len, first write byte, reads, first two reads, clears, strobes
   spr_row_t rows [0:11] = '{
      '{CMD_WR, 8'h20, 8'h02, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
      '{CMD_RD, 8'h20, 8'h02, 8'h00, 8'h02, 8'ha5, 8'ha6, 8'h00, 8'h00},
      '{CMD_RD, 8'h08, 8'h02, 8'h00, 8'h02, 8'h88, 8'h89, 8'h02, 8'h00},
      '{CMD_RD, 8'h0a, 8'h02, 8'h00, 8'h02, 8'h8a, 8'h8b, 8'h01, 8'h00},
      '{CMD_RD, 8'h0d, 8'h02, 8'h00, 8'h02, 8'h8d, 8'h8e, 8'h01, 8'h00},
      '{CMD_RD, 8'h15, 8'h02, 8'h00, 8'h02, 8'h95, 8'h96, 8'h01, 8'h00},
      '{CMD_RD, 8'h3e, 8'h03, 8'h00, 8'h03, 8'hbe, 8'h00, 8'h00, 8'h00},
      '{CMD_RD, 8'h85, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00},
      '{CMD_WR, 8'h3e, 8'h03, 8'hc1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01},
      '{CMD_FIFO, 8'h00, 8'h04, 8'h00, 8'h04, 8'h31, 8'hb1, 8'h00, 8'h00},
      '{CMD_FIFO, 8'h00, 8'h01, 8'h00, 8'h01, 8'h33, 8'h00, 8'h00, 8'h00},
      '{CMD_FIFO, 8'h00, 8'h02, 8'h00, 8'h02, 8'h34, 8'hb4, 8'h00, 8'h00}};
   spr_if link_if ();
   spr_host_end #(.HALF(SCLK_HALF_CYC), .LEN_W(8)) i_spr_host_end (.mclk(mclk), .arst_n(arst_n), .ce(1'b1),
      .link(link_if), .req(req), .req_cmd(req_cmd), .req_addr(req_addr), .req_len(req_len),
      .wr_byte(wr_byte), .wr_take(wr_take), .rd_byte(rd_byte), .rd_valid(rd_valid), .busy(busy));
   spr_dev_end i_spr_dev_end (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .link(link_if),
      .reg_rd_data({2'b10, reg_rd_addr}), .fifo_sample({2'b10, fcnt[5:0], fcnt}), .inj_en(inj_en),
      .inj_bit(inj_bit), .reg_rd_addr(reg_rd_addr), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .cfg_regs(cfg_regs), .fifo_pop(fifo_pop), .drdy_clr(drdy_clr),
      .err_user_regs(err));
   spr_link_properties i_spr_link_properties (.mclk(mclk), .arst_n(arst_n), .cs_n(link_if.cs_n),
      .sclk(link_if.sclk), .mosi(link_if.mosi), .miso_o(link_if.miso_o), .miso_oe(link_if.miso_oe));
   always #10 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Monitor also plays the FIFO head and the write data source
   always @(posedge mclk) begin
      if (rd_valid === 1'b1) rq.push_back(rd_byte);
      if (reg_wr_stb === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
      if (drdy_clr === 1'b1) ndrdy++;
      if (fifo_pop === 1'b1) fcnt <= fcnt + 8'h01;
      if (wr_take === 1'b1) wr_byte <= wr_byte + 8'h01;
   end
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] n, input logic [7:0] w);
      rq.delete();
      wq.delete();
      ndrdy = 0;
      @(posedge mclk);
      req <= 1'b1;
      req_cmd <= c;
      req_addr <= a;
      req_len <= n;
      wr_byte <= w;
      @(posedge mclk);
      req <= 1'b0;
      @(posedge mclk);
      for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge mclk);
      if (busy !== 1'b0) failures++;
      // Let the device's late pulses and the link release land
      repeat (16) @(posedge mclk);
   endtask : run
   task inject(input logic [6:0] b);
      @(posedge mclk);
      inj_bit <= b;
      inj_en <= 1'b1;
      @(posedge mclk);
      inj_en <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : inject
   task conclude;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      conclude();
   end
   initial begin
      spr_row_t r;
      logic m;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("err_reset", {15'h0, err}, 16'h0001);
      chk("oe_reset", {15'h0, link_if.miso_oe}, 16'h0000);
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         r = rows[i];
         run(r.cmd, r.adr, r.len, r.w0);
         chk("reads", 16'(rq.size()), {8'h00, r.nrd});
         if (r.nrd > 0) chk("byte0", {8'h00, rq[0]}, {8'h00, r.e0});
         if (r.nrd > 1) chk("byte1", {8'h00, rq[1]}, {8'h00, r.e1});
         chk("drdy", 16'(ndrdy), {8'h00, r.nd});
         chk("writes", 16'(wq.size()), {8'h00, r.nwr});
         if (r.nwr > 0) chk("wr0", {2'b00, wq[0]}, {2'b00, r.adr[5:0], r.w0});
         $display("row %0d done", i);
      end
      chk("cfg", cfg_regs[15:0], 16'ha6a5);
      chk("err_clear", {15'h0, err}, 16'h0000);
      inject(7'd100);
      chk("err_unguarded", {15'h0, err}, 16'h0000);
      inject(7'd3);
      chk("err_single", {15'h0, err}, 16'h0001);
      run(CMD_WR, 8'h20, 8'h01, 8'ha5);
      chk("err_rewrite", {15'h0, err}, 16'h0000);
      inject(7'd3);
      inject(7'd5);
      chk("err_double", {15'h0, err}, 16'h0001);
      $display("upset test done");
      m = link_if.miso;
      run(8'h0c, 8'h20, 8'h02, 8'h00);
      chk("keep", {15'h0, link_if.miso}, {15'h0, m});
      chk("no_write", 16'(wq.size()), 16'h0000);
      $display("invalid command test done");
      conclude();
   end
endmodule : tb_spi_register_port_with_seu_check
`default_nettype wire
